// ==== hw/szdf_consts.svh ====
// Purpose: Constants for the stereo zero-detect flag block
// Assumes: Included by bare name
// Notes: Counts in frame-clock periods
`ifndef SZDF_CONSTS_SVH
`define SZDF_CONSTS_SVH
`define SZDF_ZERO_RUN_LEN 1024
`define SZDF_MODE_INDEP 1'h0
`define SZDF_MODE_COMMON 1'h1
`define SZDF_POL_HIGH 1'h0
`define SZDF_POL_LOW 1'h1
`define SZDF_MOD_LEVELS 8
`define SZDF_MOD_ORDER 4
`define SZDF_OSR 64
`define SZDF_FLAG_RST 1'h0
`define SZDF_OE_RST 1'h1
`define SZDF_OE_ON 1'h1
`define SZDF_OE_OFF 1'h0
`define SZDF_UNASSIGNED_LEVEL 1'h0
`endif

// ==== hw/szdf_pkg.sv ====
// Purpose: Types for the stereo zero-detect flag block
// Assumes: Nothing
// Notes: Sample pair carrier
package szdf_pkg;
  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } szdf_pair_t;
endpackage

// ==== hw/szdf_zero_flags.sv ====
// Purpose: Per-channel zero-run detection and zero flag outputs
// Assumes: Samples arrive from same-clock logic with a one-cycle frame strobe
// Notes: Modulator and oversampling are outside this block; constants only
`timescale 1ns/1ps
`default_nettype none
`include "szdf_consts.svh"
module szdf_zero_flags
  import szdf_pkg::*;
#(
  parameter int RUN_LEN = `SZDF_ZERO_RUN_LEN,
  parameter int OSR = `SZDF_OSR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frame_clock,
  input wire szdf_pair_t sample_in,
  input wire logic flag_mode_select,
  input wire logic flag_polarity_select,
  output logic right_zero_flag,
  output logic left_zero_flag,
  output logic left_zero_flag_oe
);
  localparam int CW = $clog2(RUN_LEN + 1);
  localparam logic [CW-1:0] RUN_TOP = CW'(RUN_LEN);

  // Elaboration checks on values the logic cannot serve
  generate
    if (RUN_LEN < 1) begin : g_bad_run
      $error("RUN_LEN must be at least 1");
    end
    if (OSR != `SZDF_OSR) begin : g_bad_osr
      $error("Combined oversampling fixed at 64");
    end
    if (`SZDF_MOD_LEVELS != 8 || `SZDF_MOD_ORDER != 4) begin : g_bad_mod
      $error("Modulator must be 8-level, fourth order");
    end
  endgenerate

  logic [1:0] zero_now;
  logic [1:0] chan_det;
  logic right_flag_ff;
  logic left_flag_ff;
  logic left_oe_ff;
  logic common_det;

  assign zero_now[0] = (sample_in.left == 24'h000000);
  assign zero_now[1] = (sample_in.right == 24'h000000);

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic [CW-1:0] run_ff;
      // Own counter per channel
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          run_ff <= '0;
        end else if (frame_clock) begin
          if (!zero_now[ch]) begin
            run_ff <= '0;
          end else if (run_ff != RUN_TOP) begin
            run_ff <= run_ff + CW'(1);
          end
        end
      end
      assign chan_det[ch] = (run_ff == RUN_TOP);
    end
  endgenerate

  assign common_det = chan_det[0] & chan_det[1];

  // Polarity: XOR with select bit, 0 high on detect, 1 low
  // Right pin: right channel flag, or common flag in mode 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      right_flag_ff <= `SZDF_FLAG_RST;
    end else if (flag_mode_select == `SZDF_MODE_COMMON) begin
      right_flag_ff <= common_det ^ flag_polarity_select;
    end else begin
      right_flag_ff <= chan_det[1] ^ flag_polarity_select;
    end
  end

  // Left pin: left channel flag, parked low when unassigned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_flag_ff <= `SZDF_FLAG_RST;
    end else if (flag_mode_select == `SZDF_MODE_COMMON) begin
      left_flag_ff <= `SZDF_UNASSIGNED_LEVEL;
    end else begin
      left_flag_ff <= chan_det[0] ^ flag_polarity_select;
    end
  end

  // Left pin enable: on during reset in either mode, then off while the pin has no assignment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_oe_ff <= `SZDF_OE_RST;
    end else if (flag_mode_select == `SZDF_MODE_COMMON) begin
      left_oe_ff <= `SZDF_OE_OFF;
    end else begin
      left_oe_ff <= `SZDF_OE_ON;
    end
  end

  assign right_zero_flag = right_flag_ff;
  assign left_zero_flag = left_flag_ff;
  assign left_zero_flag_oe = left_oe_ff;
endmodule // szdf_zero_flags
`default_nettype wire

// ==== verification/szdf_mute.sv ====
// Purpose: Mute circuit model on a zero flag
// Assumes: Flag polarity known to the circuit
// Notes: Mute is registered
`timescale 1ns/1ps
`default_nettype none
module szdf_mute(input wire logic clk,flag,pol,output logic mute);
  always_ff @(posedge clk) mute <= flag ^ pol;
endmodule // szdf_mute
`default_nettype wire

// ==== verification/szdf_sva.sv ====
// Purpose: Port checks on the zero flags
// Assumes: Mode and polarity steady around frames
// Notes: Bound from tb
`timescale 1ns/1ps
`default_nettype none
module szdf_sva import szdf_pkg::*; #(parameter int RUN_LEN=4)(input wire logic clk,rst_n,frame_clock,flag_mode_select,
  flag_polarity_select,right_zero_flag,left_zero_flag,left_zero_flag_oe,input wire szdf_pair_t sample_in);
  wire logic f=frame_clock,m=flag_mode_select,p=flag_polarity_select,r=right_zero_flag,l=left_zero_flag;
  wire logic zl=~|sample_in.left,zr=~|sample_in.right;
  default clocking @(posedge clk);endclocking
  default disable iff(!rst_n);
  oe_on_a:assert property(##1 left_zero_flag_oe==!$past(m))else $error("oe wrong");
  left_off_a:assert property(m|=>!l)else $error("left driven");
  pol_flip_a:assert property((!f)[*4]##0$changed(p)|->##[1:2]$changed(r))else $error("no flip");
  r_clear_a:assert property(f&&!zr|->##3 r==p)else $error("right stuck");
  l_clear_a:assert property(f&&!zl&&!m|->##3 l==p)else $error("left stuck");
  c_clear_a:assert property(f&&!zl&&m|->##3 r==p)else $error("common stuck");
  r_det_a:assert property((f&&zr&&!m)[*4]|->##3 r!=p)else $error("right late");
  l_det_a:assert property((f&&zl&&!m)[*4]|->##3 l!=p)else $error("left late");
endmodule // szdf_sva
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: Bench for the zero flags
// Assumes: Zero run shortened to 4
// Notes: Inputs move at negedge
`timescale 1ns/1ps
`default_nettype none
module tb import szdf_pkg::*;;
  logic clk=0,rst_n=0,fc=0,ms=0,ps=0,rf,lf,oe,mu;
  szdf_pair_t s='0;
  int n_mismatch=0,samples_checked=0;
  always #20 clk=~clk;
  szdf_zero_flags #(.RUN_LEN(4)) u_dut(.clk,.rst_n,.frame_clock(fc),.sample_in(s),.flag_mode_select(ms),
    .flag_polarity_select(ps),.right_zero_flag(rf),.left_zero_flag(lf),.left_zero_flag_oe(oe));
  szdf_mute u_mu(.clk,.flag(rf),.pol(ps),.mute(mu));
  task chk(logic a,e);samples_checked++;if(a!==e)begin n_mismatch++;$display("[ERR] %0t flag",$time);end endtask
  task fr(int n,logic l,r);repeat(n)begin @(negedge clk);fc=1;s={{24{l}},{24{r}}};end
    @(negedge clk);fc=0;repeat(4)@(negedge clk);endtask
  task t1;fr(3,0,0);chk(rf,0);fr(1,0,1);chk(lf,1);fr(4,0,0);chk(rf,1);chk(oe,1);$display("t1 end");endtask
  task t2;ps=1;fr(1,1,0);chk(lf,1);chk(rf,0);chk(mu,1);$display("t2 end");endtask
  task t3;ms=1;fr(4,0,0);chk(oe,0);chk(rf,0);chk(lf,0);fr(1,1,0);chk(rf,1);$display("t3 end");endtask
  task t4;
    @(negedge clk);rst_n=0;ms=0;ps=0;
    repeat(2)@(negedge clk);
    chk(rf,0);
    chk(lf,0);
    chk(oe,1);
    rst_n=1;
    fr(3,0,0);
    chk(rf,0);
    chk(lf,0);
    fr(1,0,0);
    chk(rf,1);
    chk(lf,1);
    $display("t4 end");
  endtask
  task test_done;$display("checked %0d bad %0d",samples_checked,n_mismatch);
    if(n_mismatch==0&&samples_checked>0)$display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;endtask
  initial begin repeat(10)@(negedge clk);rst_n=1;t1;t2;t3;t4;test_done;end
  initial begin #20000;n_mismatch++;test_done;end
endmodule // tb
bind szdf_zero_flags szdf_sva #(.RUN_LEN(RUN_LEN)) u_sva(.clk(clk),.rst_n(rst_n),.frame_clock(frame_clock),
  .flag_mode_select(flag_mode_select),.flag_polarity_select(flag_polarity_select),.right_zero_flag(right_zero_flag),
  .left_zero_flag(left_zero_flag),.left_zero_flag_oe(left_zero_flag_oe),.sample_in(sample_in));
`default_nettype wire
